// file: design/reset_and_pin_reset_state.sv
`timescale 1ns/1ns
`include "reset_seq_consts.svh"

// Overview of operation
// - held reset pin resets internal state except calendar and clock source flops
// - cpu instruction and peripheral software resets
// - calendar power-on reset sets calendar flops
// - power-lost flag reset only by calendar reset
// - after reset, enable clock generator, then boot
// - outside reset z group pins follow bus select
// - high group driven high during reset
// - low group driven low during reset
// - z group released during reset
// - clock-out group carries clock during reset
// - sync group goes zero to one
// - sdram selects go one to zero
// - bank, flag settle high; address low
// - deep idle bypasses the clock generator
module reset_and_pin_reset_state
  import reset_seq_pkg::*;
(
  // clock, enable and resets
  input  wire logic                    clock,
  input  wire logic                    clockEn,
  input  wire logic                    rst_b,
  input  wire logic                    resetPin_b,
  input  wire logic                    rtcPor_b,
  // software resets
  input  wire logic                    cpuResetInstr,
  input  wire logic [`PERIPH_RSTS-1:0] periphResetCtrl,
  // calendar flag and clock control
  input  wire logic                    rtcFlagClear,
  input  wire logic                    deepIdleMode,
  input  wire logic                    clockSourceSelect,
  // peripheral drive for the pin groups
  input  wire logic [`Z_PINS-1:0]      externalBusSelectReg,
  input  wire logic [`HIGH_PINS-1:0]   highFunc,
  input  wire logic [`LOW_PINS-1:0]    lowFunc,
  input  wire logic [`Z_PINS-1:0]      zFuncA,
  input  wire logic [`Z_PINS-1:0]      zFuncAOe,
  input  wire logic [`Z_PINS-1:0]      zFuncB,
  input  wire logic [`Z_PINS-1:0]      zFuncBOe,
  input  wire logic                    clockOutSrc,
  input  wire logic [`CKO_PINS-1:0]    clockOutFunc,
  input  wire logic [`S01_PINS-1:0]    s01Func,
  input  wire logic [`S10_PINS-1:0]    s10Func,
  input  wire logic [`SX1_PINS-1:0]    sx1Func,
  input  wire logic [`SX0_PINS-1:0]    sx0Func,
  // reset and sequencing outputs
  output logic                         hwReset_ff,
  output logic                         cpuReset_ff,
  output logic [`PERIPH_RSTS-1:0]      periphReset_ff,
  output logic                         rtcRegsReset_ff,
  output logic                         rtcPowerLostFlag_ff,
  output logic                         clockGenEnable_ff,
  output logic                         bootStart_ff,
  output logic                         clockGenBypass_ff,
  output clk_src_t                     systemClockSrc_ff,
  // pin group outputs
  output logic [`HIGH_PINS-1:0]        highPins_ff,
  output logic [`LOW_PINS-1:0]         lowPins_ff,
  output logic [`Z_PINS-1:0]           zPins_ff,
  output logic [`Z_PINS-1:0]           zPinsOe_ff,
  output logic [`CKO_PINS-1:0]         clockOutPins_ff,
  output logic [`S01_PINS-1:0]         s01Pins_ff,
  output logic [`S10_PINS-1:0]         s10Pins_ff,
  output logic [`SX1_PINS-1:0]         sx1Pins_ff,
  output logic [`SX0_PINS-1:0]         sx0Pins_ff
);

  logic                    pinSync1_ff;
  logic                    pinSync2_ff;
  logic                    hwResetActive;
  seq_state_t              state_ff;
  seq_state_t              nxtState;
  logic [`CNT_W-1:0]       settleCnt_ff;
  logic [`CNT_W-1:0]       nxtSettleCnt;
  logic [`CNT_W-1:0]       swCnt_ff;
  logic [`CNT_W-1:0]       nxtSwCnt;
  logic                    nxtHwReset;
  logic                    nxtCpuReset;
  logic [`PERIPH_RSTS-1:0] nxtPeriphReset;
  logic                    nxtClockGenEnable;
  logic                    nxtBootStart;
  logic                    nxtBypass;
  clk_src_t                nxtSrc;
  logic                    nxtRtcFlag;
  logic [`Z_PINS-1:0]      zMux;
  logic [`Z_PINS-1:0]      zMuxOe;
  logic [`HIGH_PINS-1:0]   nxtHigh;
  logic [`LOW_PINS-1:0]    nxtLow;
  logic [`Z_PINS-1:0]      nxtZ;
  logic [`Z_PINS-1:0]      nxtZOe;
  logic [`CKO_PINS-1:0]    nxtCko;
  logic [`S01_PINS-1:0]    nxtS01;
  logic [`S10_PINS-1:0]    nxtS10;
  logic [`SX1_PINS-1:0]    nxtSx1;
  logic [`SX0_PINS-1:0]    nxtSx0;

  // two-flop synchroniser on the reset pin; pulses under one clock may be missed
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pinSync1_ff <= 1'b0;
      pinSync2_ff <= 1'b0;
    end else if (clockEn) begin
      pinSync1_ff <= resetPin_b;
      pinSync2_ff <= pinSync1_ff;
    end
  end

  assign hwResetActive = !pinSync2_ff;

  // boot sequencer and reset fan-out, next values
  always_comb begin
    nxtState     = state_ff;
    nxtSettleCnt = settleCnt_ff;
    if (hwResetActive) begin
      nxtState     = SEQ_HOLD;
      nxtSettleCnt = '0;
    end else begin
      unique case (state_ff)
        SEQ_HOLD: begin
          nxtState = SEQ_CLKGEN;
        end
        SEQ_CLKGEN: begin
          if (settleCnt_ff == `CNT_W'(`CLKGEN_SETTLE_CYC - 1)) begin
            nxtState = SEQ_BOOT;
          end else begin
            nxtSettleCnt = settleCnt_ff + `CNT_ONE;
          end
        end
        SEQ_BOOT: begin
          nxtState = SEQ_RUN;
        end
        SEQ_RUN: begin
          nxtState = SEQ_RUN;
        end
      endcase
    end
    // software cpu reset stretches to a fixed width
    nxtSwCnt = '0;
    if (!hwResetActive) begin
      if (cpuResetInstr) begin
        nxtSwCnt = `CNT_W'(`CPU_SWRST_CYC);
      end else if (swCnt_ff != '0) begin
        nxtSwCnt = swCnt_ff - `CNT_ONE;
      end
    end
    nxtHwReset        = hwResetActive;
    nxtCpuReset       = hwResetActive || (nxtSwCnt != '0);
    nxtPeriphReset    = {`PERIPH_RSTS{hwResetActive}} | periphResetCtrl;
    nxtClockGenEnable = (nxtState != SEQ_HOLD);
    nxtBootStart      = (nxtState == SEQ_BOOT) && (state_ff != SEQ_BOOT);
  end

  // system clock source: generator bypassed only in deep idle
  always_comb begin
    nxtBypass = deepIdleMode;
    if (!deepIdleMode) begin
      nxtSrc = SRC_CLKGEN;
    end else if (clockSourceSelect) begin
      nxtSrc = SRC_INPUT_REF;
    end else begin
      nxtSrc = SRC_CALENDAR;
    end
  end

  // sequencer registers
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_ff          <= SEQ_HOLD;
      settleCnt_ff      <= '0;
      swCnt_ff          <= '0;
      hwReset_ff        <= 1'b1;
      cpuReset_ff       <= 1'b1;
      periphReset_ff    <= '1;
      clockGenEnable_ff <= 1'b0;
      bootStart_ff      <= 1'b0;
      clockGenBypass_ff <= 1'b0;
      systemClockSrc_ff <= SRC_CLKGEN;
    end else if (clockEn) begin
      state_ff          <= nxtState;
      settleCnt_ff      <= nxtSettleCnt;
      swCnt_ff          <= nxtSwCnt;
      hwReset_ff        <= nxtHwReset;
      cpuReset_ff       <= nxtCpuReset;
      periphReset_ff    <= nxtPeriphReset;
      clockGenEnable_ff <= nxtClockGenEnable;
      bootStart_ff      <= nxtBootStart;
      clockGenBypass_ff <= nxtBypass;
      systemClockSrc_ff <= nxtSrc;
    end
  end

  // calendar domain: only its own power-on reset touches it, so the flag
  // survives pin resets and tells software the time must be reloaded
  always_comb begin
    nxtRtcFlag = rtcFlagClear ? 1'b0 : rtcPowerLostFlag_ff;
  end

  always_ff @(posedge clock or negedge rtcPor_b) begin
    if (!rtcPor_b) begin
      rtcRegsReset_ff     <= 1'b1;
      rtcPowerLostFlag_ff <= 1'b1;
    end else if (clockEn) begin
      rtcRegsReset_ff     <= 1'b0;
      rtcPowerLostFlag_ff <= nxtRtcFlag;
    end
  end

  // per-pin peripheral select for the shared pins
  genvar gi;
  generate
    for (gi = 0; gi < `Z_PINS; gi++) begin : gZMux
      assign zMux[gi]   = externalBusSelectReg[gi] ? zFuncB[gi] : zFuncA[gi];
      assign zMuxOe[gi] = externalBusSelectReg[gi] ? zFuncBOe[gi] : zFuncAOe[gi];
    end
  endgenerate

  // pin groups: fixed levels in reset (clock-out carries clockOutSrc), peripheral drive outside it
  always_comb begin
    nxtHigh = hwResetActive ? '1 : highFunc;
    nxtLow  = hwResetActive ? '0 : lowFunc;
    nxtZ    = hwResetActive ? '0 : zMux;
    nxtZOe  = hwResetActive ? '0 : zMuxOe;
    nxtCko  = hwResetActive ? {`CKO_PINS{clockOutSrc}} : clockOutFunc;
    nxtS01  = hwResetActive ? '0 : s01Func;
    nxtS10  = hwResetActive ? '1 : s10Func;
    nxtSx1  = hwResetActive ? '1 : sx1Func;
    nxtSx0  = hwResetActive ? '0 : sx0Func;
  end

  // pin registers; x-groups come up at a plain zero, then settle in reset
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      highPins_ff     <= '1;
      lowPins_ff      <= '0;
      zPins_ff        <= '0;
      zPinsOe_ff      <= '0;
      clockOutPins_ff <= '0;
      s01Pins_ff      <= '0;
      s10Pins_ff      <= '1;
      sx1Pins_ff      <= '0;
      sx0Pins_ff      <= '0;
    end else if (clockEn) begin
      highPins_ff     <= nxtHigh;
      lowPins_ff      <= nxtLow;
      zPins_ff        <= nxtZ;
      zPinsOe_ff      <= nxtZOe;
      clockOutPins_ff <= nxtCko;
      s01Pins_ff      <= nxtS01;
      s10Pins_ff      <= nxtS10;
      sx1Pins_ff      <= nxtSx1;
      sx0Pins_ff      <= nxtSx0;
    end
  end

  // checks on reset fan-out, boot sequencing, calendar flags, deep idle clock source and pin levels
  AST_HW_RESET: assert property (@(posedge clock) disable iff (!rst_b)
    clockEn && hwResetActive |=> cpuReset_ff && hwReset_ff && !clockGenEnable_ff
                                 && (periphReset_ff == '1))
    else $error("hardware reset did not reach internal state");

  AST_SW_CPU_RESET: assert property (@(posedge clock) disable iff (!rst_b)
    clockEn && cpuResetInstr && !hwResetActive |=> cpuReset_ff [*4])
    else $error("cpu software reset shorter than expected");

  AST_PERIPH_RESET: assert property (@(posedge clock) disable iff (!rst_b)
    clockEn && !hwResetActive |=> periphReset_ff == $past(periphResetCtrl))
    else $error("peripheral reset does not follow software control");

  AST_RTC_POR: assert property (@(posedge clock) disable iff (!rtcPor_b)
    rtcRegsReset_ff && clockEn |=> !rtcRegsReset_ff)
    else $error("calendar reset stretched beyond power-on");

  AST_RTC_FLAG_KEEP: assert property (@(posedge clock) disable iff (!rtcPor_b)
    rtcPowerLostFlag_ff && !rtcFlagClear |=> rtcPowerLostFlag_ff)
    else $error("power-lost flag cleared without software or por");

  AST_CLKGEN_START: assert property (@(posedge clock) disable iff (!rst_b)
    clockEn && $fell(hwResetActive) |=> clockGenEnable_ff && !bootStart_ff)
    else $error("clock generator not enabled on reset release");

  AST_BOOT_AFTER_CLKGEN: assert property (@(posedge clock) disable iff (!rst_b)
    $rose(bootStart_ff) |-> $past(clockGenEnable_ff, 5) ##1 !bootStart_ff || !$past(clockEn))
    else $error("boot started before clock generator settled");

  AST_MUX_FOLLOW: assert property (@(posedge clock) disable iff (!rst_b)
    clockEn && !hwResetActive |=> zPins_ff == $past(zMux) && zPinsOe_ff == $past(zMuxOe))
    else $error("shared pins not driven by selected peripheral");

  AST_HIGH_LOW: assert property (@(posedge clock) disable iff (!rst_b)
    clockEn && hwResetActive |=> highPins_ff == '1 && lowPins_ff == '0)
    else $error("high or low group wrong during reset");

  AST_Z_RELEASED: assert property (@(posedge clock) disable iff (!rst_b)
    clockEn && hwResetActive |=> zPinsOe_ff == '0)
    else $error("z group driven during reset");

  AST_CLOCK_OUT: assert property (@(posedge clock) disable iff (!rst_b)
    clockEn && hwResetActive |=> clockOutPins_ff == {`CKO_PINS{$past(clockOutSrc)}})
    else $error("clock-out group not carrying clock in reset");

  AST_SYNC_EDGES: assert property (@(posedge clock) disable iff (!rst_b)
    clockEn && hwResetActive ##1 clockEn && !hwResetActive
    |-> s01Pins_ff == '0 && s10Pins_ff == '1 ##1 s01Pins_ff == $past(s01Func))
    else $error("sync group did not switch on reset release");

  AST_SETTLE: assert property (@(posedge clock) disable iff (!rst_b)
    clockEn && hwResetActive |=> sx1Pins_ff == '1 && sx0Pins_ff == '0 && s10Pins_ff == '1)
    else $error("settling groups wrong during reset");

  AST_DEEP_IDLE: assert property (@(posedge clock) disable iff (!rst_b)
    clockEn && deepIdleMode |=> clockGenBypass_ff && systemClockSrc_ff ==
      ($past(clockSourceSelect) ? SRC_INPUT_REF : SRC_CALENDAR))
    else $error("deep idle clock source wrong");

  AST_PIN_SYNC: assert property (@(posedge clock) disable iff (!rst_b)
    clockEn && !resetPin_b ##1 clockEn |=> hwResetActive)
    else $error("reset pin not seen after two clocks");

  // main scenarios
  COV_BOOT: cover property (@(posedge clock) disable iff (!rst_b) $rose(bootStart_ff));
  COV_SW_RESET: cover property (@(posedge clock) disable iff (!rst_b)
    cpuResetInstr && state_ff == SEQ_RUN);
  COV_IDLE_CAL: cover property (@(posedge clock) disable iff (!rst_b)
    systemClockSrc_ff == SRC_CALENDAR);
  COV_FLAG_CLEAR: cover property (@(posedge clock) disable iff (!rtcPor_b)
    $fell(rtcPowerLostFlag_ff));

endmodule : reset_and_pin_reset_state

// file: design/reset_seq_consts.svh
`ifndef RESET_SEQ_CONSTS_SVH
`define RESET_SEQ_CONSTS_SVH

// clock rate and timing figures
`define CLK_PERIOD_NS      40
`define CLKGEN_SETTLE_NS   200
`define CLKGEN_SETTLE_CYC  ((`CLKGEN_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CPU_SWRST_CYC      4
`define CNT_W              4
`define CNT_ONE            4'h1

// pin group widths and peripheral reset count
`define HIGH_PINS          11
`define LOW_PINS           5
`define Z_PINS             49
`define CKO_PINS           2
`define S01_PINS           3
`define S10_PINS           2
`define SX1_PINS           3
`define SX0_PINS           21
`define PERIPH_RSTS        8

`endif

// file: design/reset_seq_pkg.sv
package reset_seq_pkg;

  // boot sequencer, gray coded along hold -> clkgen -> boot -> run
  typedef enum logic [1:0] {
    SEQ_HOLD   = 2'h0,
    SEQ_CLKGEN = 2'h1,
    SEQ_BOOT   = 2'h3,
    SEQ_RUN    = 2'h2
  } seq_state_t;

  // source of the system clock
  typedef enum logic [1:0] {
    SRC_CLKGEN    = 2'h0,
    SRC_INPUT_REF = 2'h1,
    SRC_CALENDAR  = 2'h2
  } clk_src_t;

endpackage : reset_seq_pkg

// file: verification/reset_source.sv
`timescale 1ns/1ns

// board reset source: pulls the reset pin low for a requested number of clocks
module reset_source (
  // clock and request
  input  wire logic       clock,
  input  wire logic       pulseReq,
  input  wire logic [3:0] holdLen,
  // reset pin
  output logic            resetPin_b
);
  logic [3:0] holdCnt;

  initial begin
    resetPin_b = 1'b1;
    holdCnt    = 4'h0;
  end

  // never shorter than three clocks, so every pulse is recognised
  always @(negedge clock) begin
    if (pulseReq && holdCnt == 4'h0) begin
      holdCnt    <= (holdLen < 4'h3) ? 4'h3 : holdLen;
      resetPin_b <= 1'b0;
    end else if (holdCnt > 4'h1) begin
      holdCnt <= holdCnt - 4'h1;
    end else begin
      holdCnt    <= 4'h0;
      resetPin_b <= 1'b1;
    end
  end
endmodule : reset_source

// file: verification/test_reset_and_pin_reset_state.sv
`timescale 1ns/1ns
`include "reset_seq_consts.svh"

module test_reset_and_pin_reset_state
  import reset_seq_pkg::*;
;
  logic clock, clockEn, rst_b, resetPin_b, rtcPor_b, cpuResetInstr, rtcFlagClear;
  logic deepIdleMode, clockSourceSelect, clockOutSrc, pulseReq;
  logic hwReset_ff, cpuReset_ff, rtcRegsReset_ff, rtcPowerLostFlag_ff;
  logic clockGenEnable_ff, bootStart_ff, clockGenBypass_ff;
  logic [`PERIPH_RSTS-1:0] periphResetCtrl, periphReset_ff;
  logic [`Z_PINS-1:0]      externalBusSelectReg, zFuncA, zFuncAOe, zFuncB, zFuncBOe;
  logic [`Z_PINS-1:0]      zPins_ff, zPinsOe_ff;
  logic [`HIGH_PINS-1:0]   highFunc, highPins_ff;
  logic [`LOW_PINS-1:0]    lowFunc, lowPins_ff;
  logic [`CKO_PINS-1:0]    clockOutFunc, clockOutPins_ff;
  logic [`S01_PINS-1:0]    s01Func, s01Pins_ff;
  logic [`S10_PINS-1:0]    s10Func, s10Pins_ff;
  logic [`SX1_PINS-1:0]    sx1Func, sx1Pins_ff;
  logic [`SX0_PINS-1:0]    sx0Func, sx0Pins_ff;
  clk_src_t                systemClockSrc_ff;
  int                      miscompares = 0;
  int                      cmpCount = 0;

  reset_and_pin_reset_state reset_and_pin_reset_state_i (
    .clock, .clockEn, .rst_b, .resetPin_b, .rtcPor_b, .cpuResetInstr, .periphResetCtrl,
    .rtcFlagClear, .deepIdleMode, .clockSourceSelect, .externalBusSelectReg, .highFunc,
    .lowFunc, .zFuncA, .zFuncAOe, .zFuncB, .zFuncBOe, .clockOutSrc, .clockOutFunc,
    .s01Func, .s10Func, .sx1Func, .sx0Func, .hwReset_ff, .cpuReset_ff, .periphReset_ff,
    .rtcRegsReset_ff, .rtcPowerLostFlag_ff, .clockGenEnable_ff, .bootStart_ff,
    .clockGenBypass_ff, .systemClockSrc_ff, .highPins_ff, .lowPins_ff, .zPins_ff,
    .zPinsOe_ff, .clockOutPins_ff, .s01Pins_ff, .s10Pins_ff, .sx1Pins_ff, .sx0Pins_ff
  );

  reset_source reset_source_i (.clock, .pulseReq, .holdLen(4'h3), .resetPin_b);

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // inputs move on the falling edge, away from the sampling edge
  task automatic step(input int n);
    repeat (n) @(negedge clock);
  endtask : step

  task automatic stop_test();
    $display("counts: %0d compared, %0d unexpected", cmpCount, miscompares);
    if (miscompares == 0 && cmpCount > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test

  // wait for generator enable, then functional pins and the boot pulse
  task automatic boot_check();
    int i;
    i = 0;
    while (clockGenEnable_ff !== 1'b1 && i < 20) begin
      step(1);
      i++;
    end
    check("clockGenEnable", clockGenEnable_ff, 1);
    check("hwReset", hwReset_ff, 0);
    check("highPins", highPins_ff, highFunc);
    check("lowPins", lowPins_ff, lowFunc);
    check("clockOutPins", clockOutPins_ff, clockOutFunc);
    check("s01Pins", s01Pins_ff, s01Func);
    check("s10Pins", s10Pins_ff, s10Func);
    check("sx1Pins", sx1Pins_ff, sx1Func);
    check("sx0Pins", sx0Pins_ff, sx0Func);
    for (i = 1; i <= `CLKGEN_SETTLE_CYC + 1; i++) begin
      step(1);
      check("bootStart", bootStart_ff, i == `CLKGEN_SETTLE_CYC);
    end
  endtask : boot_check

  // hang guard, far beyond the forty or so clocks the tests need
  initial begin
    repeat (3000) @(posedge clock);
    miscompares++;
    stop_test();
  end

  initial begin
    logic [`Z_PINS-1:0] expZ, expOe;
    int                 i;
    clockEn = 1'b1; rst_b = 1'b0; rtcPor_b = 1'b0; pulseReq = 1'b0;
    cpuResetInstr = 1'b0; periphResetCtrl = 8'h00; rtcFlagClear = 1'b0;
    deepIdleMode = 1'b0; clockSourceSelect = 1'b0; clockOutSrc = 1'b1;
    externalBusSelectReg = 49'h0_aaaa_5555_f0f0;
    zFuncA = 49'h1_2345_6789_abcd; zFuncAOe = 49'h1_ffff_0000_ffff;
    zFuncB = 49'h0_fedc_ba98_7654; zFuncBOe = 49'h0_0f0f_f0f0_0f0f;
    highFunc = 11'h2a5; lowFunc = 5'h15; clockOutFunc = 2'h2; s01Func = 3'h5;
    s10Func = 2'h1; sx1Func = 3'h2; sx0Func = 21'h0_5a5a;
    step(4);
    check("hwReset", hwReset_ff, 1);
    check("highPins", highPins_ff, 11'h7ff);
    check("lowPins", lowPins_ff, 5'h00);
    check("zPinsOe", zPinsOe_ff, 49'h0);
    check("rtcRegsReset", rtcRegsReset_ff, 1);
    check("rtcPowerLost", rtcPowerLostFlag_ff, 1);
    rst_b <= 1'b1;
    rtcPor_b <= 1'b1;
    step(1);
    check("rtcRegsReset", rtcRegsReset_ff, 0);
    check("rtcPowerLost", rtcPowerLostFlag_ff, 1);
    boot_check();
    $display("test power-up boot done");
    // both polarities of every select bit
    for (i = 0; i < 2; i++) begin
      expZ = (externalBusSelectReg & zFuncB) | (~externalBusSelectReg & zFuncA);
      expOe = (externalBusSelectReg & zFuncBOe) | (~externalBusSelectReg & zFuncAOe);
      check("zPins", zPins_ff, expZ);
      check("zPinsOe", zPinsOe_ff, expOe);
      externalBusSelectReg <= ~externalBusSelectReg;
      step(1);
    end
    $display("test pin select done");
    cpuResetInstr <= 1'b1;
    periphResetCtrl <= 8'ha5;
    for (i = 1; i <= `CPU_SWRST_CYC + 1; i++) begin
      step(1);
      cpuResetInstr <= 1'b0;
      check("cpuReset", cpuReset_ff, i <= `CPU_SWRST_CYC);
    end
    check("periphReset", periphReset_ff, 8'ha5);
    periphResetCtrl <= 8'h00;
    step(1);
    check("periphReset", periphReset_ff, 8'h00);
    $display("test software resets done");
    // frozen enable: an instruction seen only on frozen edges must be lost
    clockEn <= 1'b0;
    cpuResetInstr <= 1'b1;
    step(2);
    clockEn <= 1'b1;
    cpuResetInstr <= 1'b0;
    step(1);
    check("cpuReset", cpuReset_ff, 0);
    $display("test clock enable done");
    // calendar, input reference, then generator again
    for (i = 0; i < 3; i++) begin
      deepIdleMode <= (i < 2);
      clockSourceSelect <= (i == 1);
      step(1);
      check("clockGenBypass", clockGenBypass_ff, i < 2);
      check("systemClockSrc", systemClockSrc_ff, (i == 0) ? SRC_CALENDAR :
            (i == 1) ? SRC_INPUT_REF : SRC_CLKGEN);
    end
    $display("test deep idle done");
    rtcFlagClear <= 1'b1;
    step(1);
    rtcFlagClear <= 1'b0;
    check("rtcPowerLost", rtcPowerLostFlag_ff, 0);
    // shortest legal pin pulse; flag must survive it untouched
    pulseReq <= 1'b1;
    step(1);
    pulseReq <= 1'b0;
    i = 0;
    while (hwReset_ff !== 1'b1 && i < 10) begin
      step(1);
      i++;
    end
    check("hwReset", hwReset_ff, 1);
    check("highPins", highPins_ff, 11'h7ff);
    check("lowPins", lowPins_ff, 5'h00);
    check("zPinsOe", zPinsOe_ff, 49'h0);
    check("clockOutPins", clockOutPins_ff, 2'h3);
    check("s01Pins", s01Pins_ff, 3'h0);
    check("s10Pins", s10Pins_ff, 2'h3);
    check("sx1Pins", sx1Pins_ff, 3'h7);
    check("sx0Pins", sx0Pins_ff, 21'h0);
    check("cpuReset", cpuReset_ff, 1);
    check("periphReset", periphReset_ff, 8'hff);
    check("clockGenEnable", clockGenEnable_ff, 0);
    boot_check();
    check("rtcPowerLost", rtcPowerLostFlag_ff, 0);
    check("rtcRegsReset", rtcRegsReset_ff, 0);
    $display("test pin reset done");
    stop_test();
  end
endmodule : test_reset_and_pin_reset_state
